// file: src/mdio_frame_defines.svh
// Constants for the management serial frame target
`ifndef MDIO_FRAME_DEFINES_SVH
`define MDIO_FRAME_DEFINES_SVH
`define CLK_PERIOD_NS      8
`define LINK_MAX_KHZ       2500
`define PREAMBLE_LEN       6'd32
`define LEAD_BASIC         2'b01
`define LEAD_EXT           2'b00
`define CMD_B_WRITE        2'b01
`define CMD_B_READ         2'b10
`define CMD_X_ADDRESS      2'b00
`define CMD_X_WRITE        2'b01
`define CMD_X_READ         2'b11
`define CMD_X_READ_INC     2'b10
`define LEAD_BITS          6'd2
`define HDR_BITS           6'd14
`define TA_BITS            6'd16
`define DATA_BITS          6'd32
`define CNT_ZERO           6'd0
`define CNT_ONE            6'd1
`define ADDR_STEP          16'h0001
`define ADDR_RESET         16'h0000
`endif

// file: src/mdio_frame_pkg.sv
// Types for the management serial frame target
package mdio_frame_pkg;
   typedef enum logic [2:0]
   {
      st_idle     = 3'b000,
      st_header   = 3'b001,
      st_handover = 3'b010,
      st_data     = 3'b011,
      st_skip     = 3'b100
   } frame_state_e;
   typedef logic [15:0] word_t;
   typedef logic [4:0]  field_t;
endpackage

// file: src/mdio_management_frame.sv
// Managed target end of the two-wire management serial bus
// Notes on behaviour
// RL1 - Only the master starts frames and makes the clock; this target only answers.
// RL2 - The target works at any link clock rate up to 2.5 MHz.
// RL3 - A basic frame opens with lead code 01.
// RL4 - After the lead code come command, device number, register index, handover, data.
// RL5 - Basic frames reach 32 registers in each of 32 devices.
// RL6 - A two-bit handover after the address lets the target take the line on reads.
// RL7 - In basic frames the master drives write data and the target drives read data.
// RL8 - An extended frame opens with lead code 00.
// RL9 - Extended access is an address frame followed by a read or write frame.
// RL10 - Extended commands are address, write, read and read with increment.
// RL11 - In extended frames the register index field selects the target unit kind.
// RL12 - Master drives address and write words; target drives read and read-increment words.
// RL13 - An extended target holds a 16-bit register address set by the address frame.
// RL14 - Basic and extended devices share the bus; each acts only on its own lead codes.
// RL15 - Master sends 32 ones of preamble and leaves the line released high while idle.
// RL16 - Data is sampled on rising clock edges and the driver changes it after the edge.
// RL17 - Basic 01 write, 10 read; extended 00 address, 01 write, 11 read, 10 read-increment.
`timescale 1ns/100ps
`include "mdio_frame_defines.svh"
module mdio_management_frame
(
   input  wire logic                    mclk,
   input  wire logic                    rst,
   input  wire logic                    mgmt_clk,
   input  wire logic                    mgmt_data_in,
   output logic                         mgmt_data_out,
   output logic                         mgmt_data_oe,
   input  wire mdio_frame_pkg::field_t  line_device_number,
   input  wire logic                    basic_enable,
   input  wire logic                    ext_enable,
   input  wire mdio_frame_pkg::word_t   read_data,
   output mdio_frame_pkg::field_t       register_index,
   output mdio_frame_pkg::field_t       target_unit_kind,
   output mdio_frame_pkg::word_t        ext_address,
   output logic                         is_extended,
   output mdio_frame_pkg::word_t        write_data,
   output logic                         write_strobe,
   output logic                         read_strobe
);
   import mdio_frame_pkg::*;

   // ==========================================================
   // Link sampling
   // Link clock is oversampled; 125 MHz gives ample margin at 2.5 MHz (see RL2)
   logic [1:0]   clk_sync_ff;
   logic [1:0]   dat_sync_ff;
   logic         clk_last_ff;
   logic         rise;
   logic         fall;

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         clk_sync_ff <= 2'b00;
         dat_sync_ff <= 2'b11;
         clk_last_ff <= 1'b0;
      end
      else
      begin
         clk_sync_ff <= {clk_sync_ff[0], mgmt_clk};
         dat_sync_ff <= {dat_sync_ff[0], mgmt_data_in};
         clk_last_ff <= clk_sync_ff[1];
      end
   end

   assign rise = clk_sync_ff[1] & ~clk_last_ff; // see RL16
   assign fall = ~clk_sync_ff[1] & clk_last_ff; // see RL16

   function automatic logic is_read(input logic ext, input logic [1:0] cmd);
      if (ext)
         is_read = (cmd == `CMD_X_READ) || (cmd == `CMD_X_READ_INC); // see RL12
      else
         is_read = (cmd == `CMD_B_READ); // see RL7
   endfunction

   // ==========================================================
   // Frame decoder
   frame_state_e state_ff;
   logic [5:0]   ones_ff;
   logic [5:0]   bit_ff;
   logic [13:0]  hdr_ff;
   logic [15:0]  shift_ff;
   logic         mine;
   logic         hdr_ext;

   // Header bits: lead[13:12] cmd[11:10] dev[9:5] idx[4:0]
   assign hdr_ext = (hdr_ff[13:12] == `LEAD_EXT); // see RL3 RL8
   assign mine    = (hdr_ff[9:5] == line_device_number)
                    && (hdr_ext ? ext_enable : basic_enable); // see RL14

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         state_ff <= st_idle;
         ones_ff  <= `CNT_ZERO;
         bit_ff   <= `CNT_ZERO;
         hdr_ff   <= 14'h0000;
         shift_ff <= 16'h0000;
      end
      else if (rise)
      begin
         case (state_ff)
            st_idle:
            begin
               // Exactly 32 ones, then the first zero of either lead code; a 33rd one opens
               // a lead 1x frame, so a longer preamble costs the frame behind it
               if (dat_sync_ff[1] && ones_ff == `PREAMBLE_LEN)
               begin
                  ones_ff  <= `CNT_ZERO;
                  state_ff <= st_skip; // see RL14
                  bit_ff   <= `CNT_ONE;
               end
               else if (dat_sync_ff[1])
                  ones_ff <= ones_ff + `CNT_ONE;
               else
               begin
                  ones_ff <= `CNT_ZERO;
                  if (ones_ff == `PREAMBLE_LEN) // see RL15
                  begin
                     state_ff <= st_header;
                     bit_ff   <= `CNT_ONE;
                     hdr_ff   <= 14'h0000;
                  end
               end
            end
            st_header:
            begin
               hdr_ff <= {hdr_ff[12:0], dat_sync_ff[1]}; // see RL4
               bit_ff <= bit_ff + `CNT_ONE;
               // Lead code 1x never gets here, so every full header goes on to handover
               if (bit_ff == `HDR_BITS - `CNT_ONE)
                  state_ff <= st_handover; // see RL6
            end
            st_handover:
            begin
               bit_ff <= bit_ff + `CNT_ONE;
               if (!mine)
                  state_ff <= st_skip; // see RL14
               else if (bit_ff == `TA_BITS - `CNT_ONE)
               begin
                  state_ff <= st_data;
                  shift_ff <= read_data;
               end
            end
            st_data:
            begin
               bit_ff   <= bit_ff + `CNT_ONE;
               shift_ff <= {shift_ff[14:0], dat_sync_ff[1]};
               if (bit_ff == `DATA_BITS - `CNT_ONE)
                  state_ff <= st_idle;
            end
            st_skip:
            begin
               // Foreign frame: wait out its length so its data never looks like preamble
               bit_ff <= bit_ff + `CNT_ONE;
               if (bit_ff == `DATA_BITS - `CNT_ONE)
                  state_ff <= st_idle;
            end
            default:
               state_ff <= st_idle;
         endcase
      end
   end

   // ==========================================================
   // Register side strobes and held extended address
   logic         last_bit;
   logic [1:0]   cmd;
   logic         rd;

   assign cmd      = hdr_ff[11:10];
   assign rd       = is_read(hdr_ext, cmd);
   assign last_bit = rise && (state_ff == st_data) && (bit_ff == `DATA_BITS - `CNT_ONE);

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         register_index   <= 5'h00;
         target_unit_kind <= 5'h00;
         is_extended      <= 1'b0;
         ext_address      <= `ADDR_RESET;
         write_data       <= 16'h0000;
         write_strobe     <= 1'b0;
         read_strobe      <= 1'b0;
      end
      else
      begin
         write_strobe <= 1'b0;
         read_strobe  <= 1'b0;
         if (rise && state_ff == st_handover && bit_ff == `TA_BITS - `CNT_ONE && mine)
         begin
            is_extended <= hdr_ext;
            if (hdr_ext)
               target_unit_kind <= hdr_ff[4:0]; // see RL11
            else
               register_index <= hdr_ff[4:0]; // see RL5
            read_strobe <= rd;
         end
         if (last_bit && !rd)
         begin
            if (hdr_ext && cmd == `CMD_X_ADDRESS)
               ext_address <= {shift_ff[14:0], dat_sync_ff[1]}; // see RL13
            else if (cmd == (hdr_ext ? `CMD_X_WRITE : `CMD_B_WRITE))
            begin
               write_data   <= {shift_ff[14:0], dat_sync_ff[1]};
               write_strobe <= 1'b1; // see RL17
            end
         end
         if (last_bit && hdr_ext && cmd == `CMD_X_READ_INC)
            ext_address <= ext_address + `ADDR_STEP; // see RL10
      end
   end

   // ==========================================================
   // Line driver: second handover bit drives 0, then read word MSB first
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         mgmt_data_out <= 1'b1;
         mgmt_data_oe  <= 1'b0;
      end
      else if (fall)
      begin
         if (state_ff == st_handover && bit_ff == `TA_BITS - `CNT_ONE && mine && rd)
         begin
            mgmt_data_oe  <= 1'b1; // see RL6
            mgmt_data_out <= 1'b0;
         end
         else if (state_ff == st_data && rd && bit_ff != `DATA_BITS)
         begin
            mgmt_data_oe  <= 1'b1; // see RL12
            mgmt_data_out <= shift_ff[15];
         end
         else
         begin
            mgmt_data_oe  <= 1'b0; // see RL16
            mgmt_data_out <= 1'b1;
         end
      end
      else if (state_ff == st_idle)
      begin
         mgmt_data_oe  <= 1'b0;
         mgmt_data_out <= 1'b1;
      end
   end
endmodule

// file: sim/mdio_frame_chk.sv
// Assertion checker for the management frame target
`timescale 1ns/100ps
module mdio_frame_chk
(
   input wire logic                  mclk,
   input wire logic                  rst,
   input wire logic                  mgmt_data_out,
   input wire logic                  mgmt_data_oe,
   input wire mdio_frame_pkg::word_t ext_address,
   input wire logic                  is_extended,
   input wire mdio_frame_pkg::word_t write_data,
   input wire logic                  write_strobe,
   input wire logic                  read_strobe
);
   import mdio_frame_pkg::*;
   logic rd_seen_ff;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // ==========================================
   // Helper: a read stays pending until the line is handed back
   always_ff @(posedge mclk)
   begin
      if (rst || $fell(mgmt_data_oe))
         rd_seen_ff <= 1'b0;
      else if (read_strobe)
         rd_seen_ff <= 1'b1;
   end
   // ==========================================
   // Properties
   a_wr_pulse: assert property (write_strobe |=> !write_strobe)
      else $error("write strobe longer than one cycle");
   a_rd_pulse: assert property (read_strobe |=> !read_strobe)
      else $error("read strobe longer than one cycle");
   // 40 cycles covers half a link period at the top rate plus the synchroniser
   a_oe_follows: assert property ($rose(mgmt_data_oe) |-> ##[1:40] read_strobe)
      else $error("line taken without a read handover");
   a_oe_cause: assert property ($fell(mgmt_data_oe) |-> rd_seen_ff)
      else $error("line released without a read frame");
   a_strobe_on_line: assert property (read_strobe |-> mgmt_data_oe && !mgmt_data_out)
      else $error("second handover bit not driven low");
   a_first_zero: assert property ($rose(mgmt_data_oe) |-> !mgmt_data_out)
      else $error("handover bit driven as one");
   a_release_high: assert property (!mgmt_data_oe |-> mgmt_data_out)
      else $error("released output not high");
   a_wdata_hold: assert property ($changed(write_data) |-> write_strobe)
      else $error("write data moved without strobe");
   a_addr_ext: assert property ($changed(ext_address) |-> is_extended)
      else $error("address moved by a basic frame");
   a_no_drive_wr: assert property (write_strobe |-> !mgmt_data_oe)
      else $error("target drove line on a write");
endmodule
bind mdio_management_frame mdio_frame_chk i_chk
(
   .mclk, .rst, .mgmt_data_out, .mgmt_data_oe, .ext_address, .is_extended,
   .write_data, .write_strobe, .read_strobe
);

// file: sim/mdio_master_model.sv
// Management master model making the link clock and frames
`timescale 1ns/100ps
module mdio_master_model
(
   output logic      mgmt_clk,
   output logic      m_oe,
   output logic      m_out,
   input  wire logic line
);
   // ==========================================
   // Frame engine
   initial
   begin
      mgmt_clk = 1'b0; // Clock stands still between frames
      m_oe = 1'b0; // Idle line left to the pull-up
      m_out = 1'b1;
   end
   task automatic frame(input logic [31:0] w, input logic rd, output logic [15:0] q);
      int i;
      #3; // Off the system clock edges, always 3 ns after a system clock rise
      for (i = 0; i < 64; i++)
      begin
         m_oe = !(rd && i >= 46); // Released for handover
         m_out = (i < 32) ? 1'b1 : w[63 - i];
         #32 mgmt_clk = 1'b1; // Only the master clocks, 64 ns period
         if (i >= 48)
            q[63 - i] = line; // Sampled at the rise
         #32 mgmt_clk = 1'b0;
      end
      m_oe = 1'b0;
   endtask
endmodule

// file: sim/tb.sv
// Self-checking bench for the management frame target
`timescale 1ns/100ps
module tb;
   import mdio_frame_pkg::*;
   logic mclk, rst, mgmt_clk, m_oe, m_out, dut_out, dut_oe, line, basic_enable, ext_enable;
   logic is_extended, write_strobe, read_strobe;
   field_t dev, ix, register_index, target_unit_kind, ix_exp, kind_exp;
   word_t read_data, write_data, ext_address, ea, wd, wexp;
   logic [31:0] rnd;
   int num_errors, samples_checked, wr_cnt, rd_cnt, it;
   // Pull-up wins when nobody drives
   assign line = m_oe ? m_out : (dut_oe ? dut_out : 1'b1);
   mdio_master_model i_master (.mgmt_clk, .m_oe, .m_out, .line);
   mdio_management_frame i_dut
   (
      .mclk, .rst, .mgmt_clk, .mgmt_data_in(line), .mgmt_data_out(dut_out),
      .mgmt_data_oe(dut_oe), .line_device_number(dev), .basic_enable, .ext_enable,
      .read_data, .register_index, .target_unit_kind, .ext_address, .is_extended,
      .write_data, .write_strobe, .read_strobe
   );
   always #4 mclk = ~mclk;
   always @(posedge mclk)
   begin
      wr_cnt <= wr_cnt + (write_strobe === 1'b1);
      rd_cnt <= rd_cnt + (read_strobe === 1'b1);
   end
   // ==========================================
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic word_t exp_q(input logic ok);
      return ok ? read_data : 16'hffff;
   endfunction
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic op(input logic [1:0] ld, input logic [1:0] cm, input field_t dv,
                     input word_t dd, input logic rd, input logic ok);
      word_t q;
      int w0;
      int r0;
      w0 = wr_cnt;
      r0 = rd_cnt;
      i_master.frame({ld, cm, dv, ix, 2'b10, dd}, rd, q);
      repeat (8) @(posedge mclk);
      if (rd)
         check("read word", exp_q(ok), q);
      check("write pulses", ok && !rd && cm != 2'b00, wr_cnt - w0);
      check("read pulses", ok && rd, rd_cnt - r0);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ==========================================
   // Main sequence: four passes, the first two with both formats enabled, the last two drop one format each
   initial
   begin
      mclk = 1'b0;
      rst = 1'b1;
      rnd = 32'h0fa3c23a;
      dev <= rnd[4:0];
      {basic_enable, ext_enable} <= 2'b11;
      read_data <= 16'h0000;
      {ea, wexp, ix_exp, kind_exp} = '0;
      {num_errors, samples_checked} = '0;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      for (it = 0; it < 4; it++)
      begin
         rnd = lfsr(rnd);
         ix = (it == 0) ? 5'h1f : rnd[9:5];
         wd = rnd[31:16];
         basic_enable <= (it != 2);
         ext_enable <= (it != 3);
         read_data <= rnd[23:8];
         @(posedge mclk);
         op(2'b01, 2'b01, dev, wd, 1'b0, basic_enable);
         if (basic_enable)
            {wexp, ix_exp} = {wd, ix};
         check("write data", wexp, write_data);
         check("reg index", ix_exp, register_index);
         check("format", !basic_enable, is_extended);
         op(2'b01, 2'b10, dev, 16'h0000, 1'b1, basic_enable);
         op(2'b00, 2'b00, dev, (it == 0) ? 16'hffff : rnd[25:10], 1'b0, ext_enable);
         if (ext_enable)
            ea = (it == 0) ? 16'hffff : rnd[25:10];
         if (ext_enable)
            kind_exp = ix;
         check("ext address", ea, ext_address);
         check("unit kind", kind_exp, target_unit_kind);
         check("format", ext_enable, is_extended);
         op(2'b00, 2'b01, dev, ~wd, 1'b0, ext_enable);
         if (ext_enable)
            wexp = ~wd;
         check("write data", wexp, write_data);
         op(2'b00, 2'b10, dev, 16'h0000, 1'b1, ext_enable);
         if (ext_enable)
            ea = ea + 16'h0001;
         check("ext address", ea, ext_address);
         op(2'b00, 2'b11, dev, 16'h0000, 1'b1, ext_enable);
         check("ext address", ea, ext_address);
         op(2'b01, 2'b10, dev + 5'h01, 16'h0000, 1'b1, 1'b0);
         op(2'b11, 2'b10, dev, 16'h0000, 1'b1, 1'b0);
         $display("test %0d done", it);
      end
      end_of_test;
   end
   initial
   begin
      #400000; // About three times the 32 frames of 4.2 us
      num_errors++;
      end_of_test;
   end
endmodule
